// file: include/rpd_pkg.sv
// Purpose: Constants and types for the reset sequencer and PHY energy power-down
// Assumes: 125 MHz mclk, Avalon-MM register slave with waitrequest
// Notes: Register offsets are byte addresses of 32-bit words
package rpd_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // Times in their own units
    localparam int unsigned POR_MAX_MS = 25;
    localparam int unsigned STRAP_TYP_MS = 15;
    localparam int unsigned GLOBAL_SOFT_RESET_BIT_NS = 2000;
    localparam int unsigned PHY_RST_US = 100;
    localparam int unsigned PHY_REG_RST_US = 100;
    localparam int unsigned EEPROM_PROBE_US = 10;
    // Cycle counts; nanosecond times round down
    localparam int unsigned POR_CYC = POR_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned STRAP_CYC = STRAP_TYP_MS * 1000 * CLK_MHZ;
    localparam int unsigned GLOBAL_SOFT_RESET_BIT_CYC = (GLOBAL_SOFT_RESET_BIT_NS * CLK_MHZ) / 1000;
    localparam int unsigned PHY_RST_CYC = PHY_RST_US * CLK_MHZ;
    localparam int unsigned PHY_REG_RST_CYC = PHY_REG_RST_US * CLK_MHZ;
    localparam int unsigned EEPROM_CYC = EEPROM_PROBE_US * CLK_MHZ;
    localparam int CNT_W = 24;
    // Register byte offsets
    localparam logic [7:0] OFS_HARDWARE_CONFIG_REG = 8'h00;
    localparam logic [7:0] OFS_PMT = 8'h04;
    localparam logic [7:0] OFS_E2P = 8'h08;
    localparam logic [7:0] OFS_PHY_BCR = 8'h0c;
    localparam logic [7:0] OFS_PHY_MODE = 8'h10;
    localparam logic [7:0] OFS_PHY_INT = 8'h14;
    localparam logic [7:0] OFS_PHY_BSR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // Field positions
    localparam int GLOBAL_SOFT_RESET_BIT_BIT = 0;
    localparam int READY_BIT = 0;
    localparam int PHY_RST_BIT = 10;
    localparam int E2P_BUSY_BIT = 31;
    localparam int BCR_RST_BIT = 15;
    localparam int EDPD_BIT = 13;
    localparam int ENERGY_BIT = 1;
    localparam int LINK_BIT = 2;
    localparam int STRAP_W = 4;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0] {RPD_RUN, RPD_POR, RPD_PIN, RPD_SOFT} rpd_seq_type;

    // Block-level reset outputs grouped together
    typedef struct packed {
        logic pll;
        logic host_bus_interface;
        logic kept;
        logic mac_interface_layer;
        logic mac;
        logic phy;
    } rpd_rst_type;
endpackage : rpd_pkg

// file: rtl/rpd_reset_seq.sv
// Purpose: Reset sequencing, readiness, soft and PHY resets, energy-detect power-down
// Assumes: One clock mclk, sys_rst synchronous active high stands for power-on
// Notes: Pins from outside pass two flip-flops; outputs come from flip-flops
`timescale 1ns/10ps
module rpd_reset_seq
    import rpd_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC,
    parameter int unsigned STRAP_CYCLES = STRAP_CYC,
    parameter int unsigned PHY_RST_CYCLES = PHY_RST_CYC,
    parameter int unsigned PHY_REG_RST_CYCLES = PHY_REG_RST_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hw_reset_pin_low,
    input wire logic [STRAP_W-1:0] strap_in,
    input wire logic line_energy_raw,
    input wire logic eeprom_present,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output rpd_rst_type blk_rst,
    output logic eeprom_reload,
    output logic [STRAP_W-1:0] strap_latched,
    output logic phy_powered,
    output logic phy_tx_enable,
    output logic energy_irq
);
    // Synchronisers for pins
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [STRAP_W-1:0] strap_a;
    logic [STRAP_W-1:0] strap_b;
    logic pin_low_s;
    logic energy_s;
    logic eeprom_s;
    logic pin_low_d;
    // Sequencer
    rpd_seq_type seq;
    rpd_seq_type next_seq;
    logic [CNT_W-1:0] seq_cnt;
    logic [CNT_W-1:0] strap_cnt;
    logic strap_wait;
    logic ready;
    logic soft_bit;
    // PHY reset timers
    logic phy_rst_bit;
    logic bcr_rst_bit;
    logic [CNT_W-1:0] phy_cnt;
    logic [CNT_W-1:0] bcr_cnt;
    // Energy detect
    logic edpd_en;
    logic energy_int_en;
    logic energy_flag;
    logic energy_d;
    logic phy_up;
    logic link_up;
    // EEPROM probe
    logic e2p_busy;
    logic [CNT_W-1:0] e2p_cnt;
    // Bus
    logic wait_q;

    // Synchroniser reset value; the pin bit idles high
    localparam logic [2:0] SYNC_IDLE = 3'h1;

    // Two flip-flops on outside inputs
    // Pin bit resets to its idle level, so no false pin edge follows reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
            strap_a <= '0;
            strap_b <= '0;
        end else if (clk_en) begin
            sync_a <= {eeprom_present, line_energy_raw, hw_reset_pin_low};
            sync_b <= sync_a;
            strap_a <= strap_in;
            strap_b <= strap_a;
        end
    end
    // Synchronised levels; the pin is active low
    assign pin_low_s = ~sync_b[0];
    assign energy_s = sync_b[1];
    assign eeprom_s = sync_b[2];

    // Bus decode
    // Writes are refused until ready; reads always answer so ready can be polled
    wire bus_req = (avs_read | avs_write) & wait_q;
    wire wr_ok = avs_write & ~wait_q & ready;
    wire be_lo = avs_byteenable[0];
    wire be_hi = avs_byteenable[1];
    wire wr_hardware_config_reg = wr_ok & (avs_address == OFS_HARDWARE_CONFIG_REG) & be_lo;
    wire wr_pmt = wr_ok & (avs_address == OFS_PMT) & be_hi;
    wire wr_bcr = wr_ok & (avs_address == OFS_PHY_BCR) & be_hi;
    wire wr_mode = wr_ok & (avs_address == OFS_PHY_MODE) & be_hi;
    wire wr_int = wr_ok & (avs_address == OFS_PHY_INT) & be_lo;
    // Self-clearing reset starts
    wire start_soft = wr_hardware_config_reg & avs_writedata[GLOBAL_SOFT_RESET_BIT_BIT];
    wire start_phy = wr_pmt & avs_writedata[PHY_RST_BIT];
    wire start_bcr = wr_bcr & avs_writedata[BCR_RST_BIT];
    // Pin reset start, for the strap latch
    wire pin_start = pin_low_s & ~pin_low_d;
    wire seq_done = (seq_cnt == '0);

    // Next sequencer state; pin wins over soft reset
    // Power-on ignores the pin: its own timer must run out first
    always_comb begin
        next_seq = seq;
        case (seq)
            RPD_POR: if (seq_done) next_seq = RPD_RUN;
            RPD_PIN: if (!pin_low_s) next_seq = RPD_RUN;
            RPD_SOFT: begin
                if (pin_low_s) next_seq = RPD_PIN;
                else if (seq_done) next_seq = RPD_RUN;
            end
            RPD_RUN: begin
                if (pin_low_s) next_seq = RPD_PIN;
                else if (start_soft) next_seq = RPD_SOFT;
            end
            default: next_seq = RPD_POR;
        endcase
    end

    // Sequencer, ready flag and cycle counter
    // Ready follows the next state, so it drops the cycle a reset starts
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seq <= RPD_POR;
            seq_cnt <= CNT_W'(POR_CYCLES - 1);
            ready <= 1'b0;
            pin_low_d <= 1'b0;
        end else if (clk_en) begin
            seq <= next_seq;
            pin_low_d <= pin_low_s;
            if (next_seq == RPD_SOFT && seq != RPD_SOFT) begin
                seq_cnt <= CNT_W'(GLOBAL_SOFT_RESET_BIT_CYC - 1);
            end else if (!seq_done) begin
                seq_cnt <= seq_cnt - 1'b1;
            end
            ready <= (next_seq == RPD_RUN);
        end
    end
    // Soft reset bit reads 1 for the whole soft reset
    assign soft_bit = (seq == RPD_SOFT);

    // Strap latch after power-on and on pin assertion
    // A pin edge latches at once; the power-on latch waits its settle time
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strap_wait <= 1'b1;
            strap_cnt <= CNT_W'(STRAP_CYCLES - 1);
            strap_latched <= '0;
        end else if (clk_en) begin
            if (pin_start) begin
                strap_latched <= strap_b;
            end else if (strap_wait && seq == RPD_RUN) begin
                if (strap_cnt == '0) begin
                    strap_latched <= strap_b;
                    strap_wait <= 1'b0;
                end else begin
                    strap_cnt <= strap_cnt - 1'b1;
                end
            end
        end
    end

    // Block resets per source
    // Soft reset spares the PLL, the kept registers and the PHY
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            blk_rst <= '1;
        end else if (clk_en) begin
            blk_rst.pll <= (seq == RPD_POR) | (seq == RPD_PIN);
            blk_rst.kept <= (seq == RPD_POR) | (seq == RPD_PIN);
            blk_rst.host_bus_interface <= (seq != RPD_RUN);
            blk_rst.mac_interface_layer <= (seq != RPD_RUN);
            blk_rst.mac <= (seq != RPD_RUN);
            blk_rst.phy <= (seq == RPD_POR) | (seq == RPD_PIN) | phy_rst_bit | bcr_rst_bit;
        end
    end

    // EEPROM reload pulse and probe busy window
    // Busy spans the whole reset, so the host never sees an early clear
    // End of a power-on, pin or soft reset
    wire reset_end = (seq != RPD_RUN) & (next_seq == RPD_RUN);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            eeprom_reload <= 1'b0;
            e2p_busy <= 1'b1;
            e2p_cnt <= '0;
        end else if (clk_en) begin
            eeprom_reload <= reset_end & eeprom_s;
            if (seq != RPD_RUN) begin
                e2p_busy <= 1'b1;
                e2p_cnt <= CNT_W'(EEPROM_CYC - 1);
            end else if (e2p_cnt != '0) begin
                e2p_cnt <= e2p_cnt - 1'b1;
            end else begin
                e2p_busy <= 1'b0;
            end
        end
    end

    // PHY-only resets with self-clearing bits
    // A full reset cancels a pending PHY-only reset; it resets the PHY itself
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phy_rst_bit <= 1'b0;
            bcr_rst_bit <= 1'b0;
            phy_cnt <= '0;
            bcr_cnt <= '0;
        end else if (clk_en) begin
            if (seq == RPD_PIN || seq == RPD_POR) begin
                phy_rst_bit <= 1'b0;
                bcr_rst_bit <= 1'b0;
            end else begin
                if (start_phy) begin
                    phy_rst_bit <= 1'b1;
                    phy_cnt <= CNT_W'(PHY_RST_CYCLES - 1);
                end else if (phy_rst_bit && phy_cnt == '0) begin
                    phy_rst_bit <= 1'b0;
                end else if (phy_rst_bit) begin
                    phy_cnt <= phy_cnt - 1'b1;
                end
                if (start_bcr) begin
                    bcr_rst_bit <= 1'b1;
                    bcr_cnt <= CNT_W'(PHY_REG_RST_CYCLES - 1);
                end else if (bcr_rst_bit && bcr_cnt == '0) begin
                    bcr_rst_bit <= 1'b0;
                end else if (bcr_rst_bit) begin
                    bcr_cnt <= bcr_cnt - 1'b1;
                end
            end
        end
    end

    // Energy-detect power-down and wake flag
    // A PHY reset returns the mode bits and the flag to their defaults
    wire phy_in_rst = blk_rst.phy;
    wire energy_rise = energy_s & ~energy_d;
    wire energy_clr = wr_int & avs_writedata[ENERGY_BIT];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            edpd_en <= 1'b0;
            energy_int_en <= 1'b0;
            energy_flag <= 1'b0;
            energy_d <= 1'b0;
            phy_up <= 1'b1;
            link_up <= 1'b0;
        end else if (clk_en) begin
            energy_d <= energy_s;
            if (phy_in_rst) begin
                edpd_en <= 1'b0;
                energy_int_en <= 1'b0;
                energy_flag <= 1'b0;
                phy_up <= 1'b1;
                link_up <= 1'b0;
            end else begin
                if (wr_mode) edpd_en <= avs_writedata[EDPD_BIT];
                if (wr_mode) energy_int_en <= avs_writedata[ENERGY_BIT];
                // Set wins over clear
                if (edpd_en && energy_rise) energy_flag <= 1'b1;
                else if (energy_clr) energy_flag <= 1'b0;
                // Powered while energy present or mode off; rising edge wakes
                phy_up <= ~edpd_en | energy_s;
                link_up <= energy_s & phy_up;
            end
        end
    end

    // Outputs from flip-flops
    // Transmit is off from one cycle after the PHY reset output rises until one cycle after it falls
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phy_powered <= 1'b1;
            phy_tx_enable <= 1'b0;
            energy_irq <= 1'b0;
        end else if (clk_en) begin
            phy_powered <= phy_up;
            phy_tx_enable <= phy_up & ~phy_in_rst;
            energy_irq <= energy_flag & energy_int_en;
        end
    end

    // Read mux
    // Unmapped offsets read as zero; no read has a side effect
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            OFS_HARDWARE_CONFIG_REG: rd_mux = ZERO32 | (32'(soft_bit) << GLOBAL_SOFT_RESET_BIT_BIT);
            OFS_PMT: rd_mux = (32'(phy_rst_bit) << PHY_RST_BIT) | 32'(ready);
            OFS_E2P: rd_mux = 32'(e2p_busy) << E2P_BUSY_BIT;
            OFS_PHY_BCR: rd_mux = 32'(bcr_rst_bit) << BCR_RST_BIT;
            OFS_PHY_MODE: rd_mux = (32'(edpd_en) << EDPD_BIT) | (32'(energy_int_en) << ENERGY_BIT);
            OFS_PHY_INT: rd_mux = 32'(energy_flag) << ENERGY_BIT;
            OFS_PHY_BSR: rd_mux = 32'(link_up) << LINK_BIT;
            OFS_STATUS: rd_mux = {ZERO32[31:STRAP_W+1], strap_latched, energy_s};
            default: rd_mux = UNMAPPED_DATA;
        endcase
    end

    // Avalon slave: one wait cycle, then answer
    // Wait stays high between requests, so every access takes two cycles
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            avs_readdata <= ZERO32;
        end else if (clk_en) begin
            wait_q <= ~bus_req;
            if (bus_req && avs_read) avs_readdata <= rd_mux;
        end
    end
    assign avs_waitrequest = wait_q;
endmodule : rpd_reset_seq

// file: bench/rpd_reset_sva.sv
// Purpose: Port checker for the reset sequencer
// Assumes: Bound to rpd_reset_seq, one clock domain
// Notes: Watches outputs plus the reset, pin and bus request inputs
`timescale 1ns/10ps
module rpd_reset_sva
    import rpd_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hw_reset_pin_low,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire rpd_rst_type blk_rst,
    input wire logic eeprom_reload,
    input wire logic phy_powered,
    input wire logic phy_tx_enable,
    input wire logic energy_irq
);
    // Shared clock and reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Bus answer timing
    a_wait_answer: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
        else $error("waitrequest did not drop one cycle after request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // Reset scope per source
    a_reset_exit: assert property ($fell(sys_rst) |-> (&blk_rst) && !energy_irq)
        else $error("power-on reset did not reach every block");
    a_pin_full: assert property (!hw_reset_pin_low [*5] |-> &blk_rst)
        else $error("pin reset did not reach every block");
    a_soft_scope: assert property (blk_rst.host_bus_interface && !blk_rst.pll |-> blk_rst.mac_interface_layer && blk_rst.mac
        && !blk_rst.kept)
        else $error("soft reset scope wrong");
    a_phy_scope: assert property (blk_rst.phy && !blk_rst.pll |-> !blk_rst.kept)
        else $error("PHY reset touched kept registers");
    // Power-down, wake and reload pulse
    a_tx_off: assert property (!phy_powered |-> !phy_tx_enable)
        else $error("transmit enabled while PHY is down");
    a_irq_wake: assert property ($rose(energy_irq) |-> ##[0:2] phy_powered)
        else $error("wake interrupt without PHY power");
    a_reload_pulse: assert property (eeprom_reload |=> !eeprom_reload)
        else $error("reload pulse longer than one cycle");
    // Main scenarios reached
    c_soft: cover property ($rose(blk_rst.mac_interface_layer) && !blk_rst.pll);
    c_down: cover property ($fell(phy_powered));
    c_wake: cover property ($rose(energy_irq));
endmodule : rpd_reset_sva

// file: bench/rpd_host_model.sv
// Purpose: Host register master on Avalon-MM
// Assumes: Slave answers by lowering waitrequest at a rising edge
// Notes: Idle address and data show inverted stale values
`timescale 1ns/10ps
module rpd_host_model
    import rpd_pkg::*;
(
    input wire logic mclk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    // Idle bus at time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
    end
    // One transfer, held until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        // Held until an edge samples waitrequest low; data taken at that edge
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~wd;
    endtask : xfer
    // Poll one bit for a level, giving up after n reads
    task automatic poll(input logic [7:0] a, input int b, input logic v, input int n,
        output logic ok);
        logic [31:0] d;
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            xfer(1'b0, a, 32'h0000_0000, d);
            ok = (d[b] === v);
        end
    endtask : poll
endmodule : rpd_host_model

// file: bench/rpd_reset_seq_tb.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short counts set by parameters
// Notes: Host model issues every register access
`timescale 1ns/10ps
module rpd_reset_seq_tb
    import rpd_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin_low = 1'b1;
    logic [3:0] strap = 4'h5;
    logic energy = 1'b1;
    logic [7:0] adr;
    logic rd_s, wr_s, wreq, ok;
    logic [31:0] wdat, rdat, d;
    logic [3:0] be;
    rpd_rst_type rst_o;
    logic powered, tx_en, irq;
    logic ce = 1'b1;
    logic reload;
    logic [3:0] strap_o;
    int n_reload = 0;
    int err_count = 0;
    int n_compared = 0;
    // 125 MHz clock
    always #4 mclk = ~mclk;
    rpd_host_model u_host (.mclk(mclk), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat),
        .avs_byteenable(be));
    rpd_reset_seq #(.POR_CYCLES(20), .STRAP_CYCLES(10), .PHY_RST_CYCLES(30),
        .PHY_REG_RST_CYCLES(30)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(ce),
        .hw_reset_pin_low(pin_low), .strap_in(strap), .line_energy_raw(energy),
        .eeprom_present(1'b1), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .blk_rst(rst_o), .eeprom_reload(reload),
        .strap_latched(strap_o), .phy_powered(powered), .phy_tx_enable(tx_en),
        .energy_irq(irq));
    // Count reload pulses seen at the edge
    always @(posedge mclk) begin
        if (reload === 1'b1) n_reload <= n_reload + 1;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        u_host.xfer(1'b1, a, v, x);
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Watchdog against hangs
    initial begin
        #300000;
        err_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        u_host.xfer(1'b0, OFS_PMT, ZERO32, d);
        chk("ready_por", d[READY_BIT], 0);
        u_host.poll(OFS_PMT, READY_BIT, 1'b1, 20, ok);
        chk("ready_set", ok, 1);
        u_host.poll(OFS_E2P, E2P_BUSY_BIT, 1'b0, 700, ok);
        chk("e2p_busy", ok, 1);
        chk("reload_por", n_reload, 1);
        u_host.xfer(1'b0, 8'hfc, ZERO32, d);
        chk("unmapped", d, UNMAPPED_DATA);
        settle(12);
        u_host.xfer(1'b0, OFS_STATUS, ZERO32, d);
        chk("strap_por", d[4:1], 4'h5);
        // Soft reset keeps straps
        strap <= 4'ha;
        wr(OFS_HARDWARE_CONFIG_REG, 32'h1 << GLOBAL_SOFT_RESET_BIT_BIT);
        u_host.xfer(1'b0, OFS_HARDWARE_CONFIG_REG, ZERO32, d);
        chk("global_soft_reset_bit_bit", d[GLOBAL_SOFT_RESET_BIT_BIT], 1);
        u_host.xfer(1'b0, OFS_PMT, ZERO32, d);
        chk("ready_soft", d[READY_BIT], 0);
        u_host.poll(OFS_HARDWARE_CONFIG_REG, GLOBAL_SOFT_RESET_BIT_BIT, 1'b0, 120, ok);
        chk("global_soft_reset_bit_clear", ok, 1);
        u_host.xfer(1'b0, OFS_PMT, ZERO32, d);
        chk("ready_after", d[READY_BIT], 1);
        u_host.xfer(1'b0, OFS_STATUS, ZERO32, d);
        chk("strap_soft", d[4:1], 4'h5);
        chk("reload_soft", n_reload, 2);
        // Both PHY-only resets self-clear
        for (int i = 0; i < 2; i++) begin
            wr(i ? OFS_PHY_BCR : OFS_PMT, 32'h1 << (i ? BCR_RST_BIT : PHY_RST_BIT));
            u_host.poll(i ? OFS_PHY_BCR : OFS_PMT, i ? BCR_RST_BIT : PHY_RST_BIT, 1'b0, 20, ok);
            chk("phy_rst", ok, 1);
        end
        u_host.poll(OFS_PHY_BSR, LINK_BIT, 1'b1, 20, ok);
        chk("link_up", ok, 1);
        // Energy-detect power-down and wake
        wr(OFS_PHY_MODE, (32'h1 << EDPD_BIT) | (32'h1 << ENERGY_BIT));
        @(posedge mclk) begin
            ce <= 1'b0;
            energy <= 1'b0;
        end
        settle(8);
        chk("frozen", powered, 1);
        @(posedge mclk) ce <= 1'b1;
        settle(8);
        chk("pwr_down", {powered, tx_en}, 0);
        @(posedge mclk) energy <= 1'b1;
        settle(8);
        chk("pwr_up", powered, 1);
        chk("irq_on", irq, 1);
        u_host.xfer(1'b0, OFS_PHY_INT, ZERO32, d);
        chk("wake_flag", d[ENERGY_BIT], 1);
        wr(OFS_PHY_INT, 32'h1 << ENERGY_BIT);
        settle(2);
        chk("irq_off", irq, 0);
        wr(OFS_PHY_MODE, ZERO32);
        @(posedge mclk) energy <= 1'b0;
        settle(8);
        chk("edpd_off", powered, 1);
        // Pin reset latches new straps
        @(posedge mclk) pin_low <= 1'b0;
        settle(8);
        @(posedge mclk) pin_low <= 1'b1;
        settle(4);
        u_host.xfer(1'b0, OFS_PMT, ZERO32, d);
        chk("ready_pin", d[READY_BIT], 1);
        u_host.xfer(1'b0, OFS_STATUS, ZERO32, d);
        chk("strap_pin", d[4:1], 4'ha);
        chk("strap_out", strap_o, 4'ha);
        chk("reload_pin", n_reload, 3);
        wrap_up();
    end
endmodule : rpd_reset_seq_tb

bind rpd_reset_seq rpd_reset_sva u_sva (.mclk(mclk), .sys_rst(sys_rst),
    .hw_reset_pin_low(hw_reset_pin_low), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .blk_rst(blk_rst), .eeprom_reload(eeprom_reload),
    .phy_powered(phy_powered), .phy_tx_enable(phy_tx_enable), .energy_irq(energy_irq));
